// ### fwptr_top.sv
// Write-port qualification and test-port reset gating of the data outputs.
// Functional notes
// - Enabled write-clock rising edge stores word
// - Chip select is a second write enable
// - Asynchronous mode stores on each selected strobe rise
// - Test reset clears controller asynchronously
// - No power-up reset; reset or five highs
// - Data outputs float until controller reset
// - Mode select steers controller, floats high
// - Sample test rise, output drive starts on fall
`timescale 1ns/1ns
`include "fwptr_regs.svh"
module fwptr_top
	import fwptr_pkg::*;
(
	input  wire logic               mclk,                          // System clock, 25 MHz.
	input  wire logic               rst_n,                         // Synchronous reset, active low.
	input  wire logic               master_reset_n,                // FIFO master reset pin, active low.
	input  wire logic               write_timing_async,            // Write timing select, 1 = strobe.
	input  wire logic               write_port_io_standard_select, // Input standard strap.
	input  wire logic               write_clk,                     // Write clock or strobe pin.
	input  wire logic               write_en_n,                    // Write enable pin, active low.
	input  wire logic               write_select_n,                // Write chip select pin, active low.
	input  wire fwptr_pkg::fwptr_word_t write_data,                // Write data pins.
	input  wire logic               tck,                           // Test clock pin.
	input  wire logic               tms,                           // Test mode select pin.
	input  wire logic               tms_driven,                    // Low when the mode-select pin floats.
	input  wire logic               trst_n,                        // Test reset pin, active low.
	input  wire logic               data_oe,                       // Read side requests output drive.
	output logic                    wr_store,                      // One-cycle pulse: word stored.
	output fwptr_pkg::fwptr_word_t  wr_word,                       // Stored word, valid with wr_store.
	output logic                    io_standard_q,                 // Strap value caught at master reset.
	output logic                    tap_ready,                     // Controller has been reset once.
	output logic                    data_out_en                    // Output enable for data pins.
);
	import fwptr_pkg::*;

	// Every control pin crosses into mclk through three flops, and a new level is only
	// accepted once stages two and three agree. A glitch shorter than one mclk
	// period therefore never reaches the write or test logic; the price is a
	// latency of about four mclk cycles from pin to action.
	// Pin vector order: 8 master reset, 7 timing select, 6 standard strap,
	// 5 write clock, 4 write enable, 3 chip select, 2 test clock,
	// 1 mode select, 0 test reset.
	localparam int               PIN_N    = 9;
	localparam logic [PIN_N-1:0] PIN_IDLE = `FWPTR_PIN_IDLE;
	wire  [PIN_N-1:0]            pin_raw;
	wire  [PIN_N-1:0]            pin_d;
	wire  [PIN_N-1:0]            pin_f;
	// A floating mode-select pin reads high, as its pull-up would make it.
	assign pin_raw = {master_reset_n, write_timing_async, write_port_io_standard_select,
		write_clk, write_en_n, write_select_n, tck, tms | ~tms_driven, trst_n};

	// Each stage resets to its pin's idle level. Any other reset value would
	// show a false edge after rst_n; on the test reset pin that false edge
	// would look like a controller reset that never happened.
	for (genvar gi = 0; gi < PIN_N; gi++) begin : g_pin
		logic [2:0] stage_q;
		logic       filt_q;
		always_ff @(posedge mclk) begin
			if (!rst_n) begin
				stage_q <= {3{PIN_IDLE[gi]}};
				filt_q  <= PIN_IDLE[gi];
			end else begin
				stage_q <= {stage_q[1:0], pin_raw[gi]};
				filt_q  <= pin_d[gi];
			end
		end
		assign pin_d[gi] = (stage_q[1] == stage_q[2]) ? stage_q[2] : filt_q;
		assign pin_f[gi] = filt_q;
	end

	// Named views of the filtered pins for the logic below.
	wire mrst_d   = pin_d[8];
	wire timing_d = pin_d[7];
	wire strap_d  = pin_d[6];
	wire wclk_d   = pin_d[5];
	wire wen_d    = pin_d[4];
	wire wcs_d    = pin_d[3];
	wire tck_d    = pin_d[2];
	wire tms_d    = pin_d[1];
	wire trst_d   = pin_d[0];
	wire wclk_f   = pin_f[5];
	wire tck_f    = pin_f[2];

	// The data bus takes the same three stages, so the word leaves stage three
	// in the same cycle as the filtered write edge that stores it.
	fwptr_word_t wd_s1, wd_s2, wd_s3;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wd_s1 <= 36'h0;
			wd_s2 <= 36'h0;
			wd_s3 <= 36'h0;
		end else begin
			wd_s1 <= write_data;
			wd_s2 <= wd_s1;
			wd_s3 <= wd_s2;
		end
	end

	// Write qualification. In strobe mode the enable is ignored, since the writer
	// must tie it low there; a write is then gated by the chip select alone.
	// Both controls are taken from the filtered pins, so they are judged at the
	// same moment as the filtered write edge.
	wire wclk_rise = wclk_d & ~wclk_f;
	wire sel_ok    = ~wcs_d;
	wire en_ok     = timing_d ? 1'b1 : ~wen_d;
	wire do_store  = wclk_rise & sel_ok & en_ok;

	// One pulse per stored word; the strobe high time keeps pulses apart.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_store <= 1'b0;
		end else begin
			wr_store <= do_store;
		end
	end

	// The stored word is held until the next store so a slow reader can take it.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_word <= 36'h0;
		end else if (do_store) begin
			wr_word <= wd_s3;
		end
	end

	// The strap is caught while master reset is low and frozen afterwards, so a
	// strap that moves in operation cannot switch the input standard under traffic.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			io_standard_q <= 1'b0;
		end else if (!mrst_d) begin
			io_standard_q <= strap_d;
		end
	end

	// Test controller: the state moves on a filtered test-clock rise. The test
	// reset also passes the filter, so it acts within about four mclk cycles
	// of the pin without waiting for any test-clock edge.
	wire tck_rise = tck_d & ~tck_f;
	wire tck_fall = ~tck_d & tck_f;
	fwptr_tap_t tap_q, tap_d;
	always_comb begin
		case (tap_q)
			FWPTR_TLR:  tap_d = tms_d ? FWPTR_TLR  : FWPTR_RTI;
			FWPTR_RTI:  tap_d = tms_d ? FWPTR_SDRS : FWPTR_RTI;
			FWPTR_SDRS: tap_d = tms_d ? FWPTR_SIRS : FWPTR_CDR;
			FWPTR_CDR:  tap_d = tms_d ? FWPTR_E1DR : FWPTR_SDR;
			FWPTR_SDR:  tap_d = tms_d ? FWPTR_E1DR : FWPTR_SDR;
			FWPTR_E1DR: tap_d = tms_d ? FWPTR_UDR  : FWPTR_PDR;
			FWPTR_PDR:  tap_d = tms_d ? FWPTR_E2DR : FWPTR_PDR;
			FWPTR_E2DR: tap_d = tms_d ? FWPTR_UDR  : FWPTR_SDR;
			FWPTR_UDR:  tap_d = tms_d ? FWPTR_SDRS : FWPTR_RTI;
			FWPTR_SIRS: tap_d = tms_d ? FWPTR_TLR  : FWPTR_CIR;
			FWPTR_CIR:  tap_d = tms_d ? FWPTR_E1IR : FWPTR_SIR;
			FWPTR_SIR:  tap_d = tms_d ? FWPTR_E1IR : FWPTR_SIR;
			FWPTR_E1IR: tap_d = tms_d ? FWPTR_UIR  : FWPTR_PIR;
			FWPTR_PIR:  tap_d = tms_d ? FWPTR_E2IR : FWPTR_PIR;
			FWPTR_E2IR: tap_d = tms_d ? FWPTR_UIR  : FWPTR_SIR;
			FWPTR_UIR:  tap_d = tms_d ? FWPTR_SDRS : FWPTR_RTI;
			default:    tap_d = FWPTR_TLR;
		endcase
	end

	// Without a power-up reset the controller starts in an unknown state. The
	// model stands in for that with an idle state and tap_ready low, so nothing
	// downstream may trust the state until a real reset has been seen.
	// Five rising test clocks with mode select high are counted, because from
	// any state that many highs are certain to reach the logic-reset state.
	logic [2:0] tms_hi_q;
	wire        trst_act    = ~trst_d;
	wire        tms_hi_full = (tms_hi_q == `FWPTR_TLR_HOLD);
	wire [2:0]  tms_hi_inc  = tms_hi_full ? tms_hi_q : tms_hi_q + 3'h1;
	wire [2:0]  tms_hi_nxt  = tms_d ? tms_hi_inc : 3'h0;
	wire        hi_done     = tck_rise & tms_d & (tms_hi_q == (`FWPTR_TLR_HOLD - 3'h1));

	// The state moves only on a filtered test-clock rise; the test reset overrides it.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tap_q <= FWPTR_RTI;
		end else if (trst_act) begin
			tap_q <= FWPTR_TLR;
		end else if (tck_rise) begin
			tap_q <= tap_d;
		end
	end

	// The count saturates at five so a long run of highs cannot wrap it back.
	always_ff @(posedge mclk) begin
		if (!rst_n || trst_act) begin
			tms_hi_q <= 3'h0;
		end else if (tck_rise) begin
			tms_hi_q <= tms_hi_nxt;
		end
	end

	// The ready flag is sticky: once a reset has been seen, only rst_n clears it.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tap_ready <= 1'b0;
		end else if (trst_act || hi_done) begin
			tap_ready <= 1'b1;
		end
	end

	// The output enable may only rise on a test-clock fall once the controller
	// has been reset. Dropping data_oe takes effect on the next mclk edge, so the
	// pins are never left driving after the read side lets go.
	// Until the first reset the pins float, whatever the read side asks for.
	wire oe_block  = ~tap_ready;
	wire oe_update = tck_fall | ~data_oe;
	always_ff @(posedge mclk) begin
		if (!rst_n || oe_block) begin
			data_out_en <= 1'b0;
		end else if (oe_update) begin
			data_out_en <= data_oe;
		end
	end
endmodule

// ### fwptr_regs.svh
// Constants for the write-port qualifier and test-reset gate.
`ifndef FWPTR_REGS_SVH
`define FWPTR_REGS_SVH
`define FWPTR_DATA_W      36
`define FWPTR_TLR_HOLD    3'h5
`define FWPTR_PIN_IDLE    9'h01B
`define FWPTR_WR_TIMING_SYNC  1'h0
`define FWPTR_WR_TIMING_ASYNC 1'h1
`endif

// ### fwptr_pkg.sv
// Types shared by the write-port qualifier and test-reset gate.
package fwptr_pkg;
	typedef logic [35:0] fwptr_word_t;
	typedef enum logic [3:0] {
		FWPTR_TLR  = 4'h0,
		FWPTR_RTI  = 4'h1,
		FWPTR_SDRS = 4'h2,
		FWPTR_CDR  = 4'h3,
		FWPTR_SDR  = 4'h4,
		FWPTR_E1DR = 4'h5,
		FWPTR_PDR  = 4'h6,
		FWPTR_E2DR = 4'h7,
		FWPTR_UDR  = 4'h8,
		FWPTR_SIRS = 4'h9,
		FWPTR_CIR  = 4'hA,
		FWPTR_SIR  = 4'hB,
		FWPTR_E1IR = 4'hC,
		FWPTR_PIR  = 4'hD,
		FWPTR_E2IR = 4'hE,
		FWPTR_UIR  = 4'hF
	} fwptr_tap_t;
endpackage

// ### fwptr_top_monitor.sv
// Assertion checker for fwptr_top.
`timescale 1ns/1ns
module fwptr_mon
	import fwptr_pkg::*;
(
	input logic        mclk,               // Clock.
	input logic        rst_n,              // Reset.
	input logic        write_timing_async, // Mode.
	input logic        write_clk,          // Strobe.
	input logic        write_en_n,         // Enable.
	input logic        write_select_n,     // Select.
	input fwptr_word_t write_data,         // Data in.
	input logic        trst_n,             // Test reset.
	input logic        tck,                // Test clock.
	input logic        data_oe,            // Drive request.
	input logic        wr_store,           // Store pulse.
	input fwptr_word_t wr_word,            // Stored word.
	input logic        tap_ready,          // Reset seen.
	input logic        data_out_en         // Output enable.
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_take; $rose(write_clk) && !write_select_n && (write_timing_async || !write_en_n) |-> ##[2:6] wr_store; endproperty
	property p_sel; wr_store |-> !$past(write_select_n, 4); endproperty
	property p_en; wr_store |-> $past(write_timing_async, 4) || !$past(write_en_n, 4); endproperty
	property p_word; wr_store |-> wr_word == $past(write_data, 4); endproperty
	property p_pulse; wr_store |=> !wr_store; endproperty
	property p_trst; $fell(trst_n) |-> ##[1:6] tap_ready; endproperty
	property p_cold; $rose(rst_n) |-> !tap_ready && !data_out_en; endproperty
	property p_gate; data_out_en |-> tap_ready; endproperty
	property p_drop; !data_oe |=> !data_out_en; endproperty
	property p_fall; $rose(data_out_en) |-> !tck; endproperty
	a_take: assert property (p_take) else $error("store missing");
	a_sel: assert property (p_sel) else $error("store while deselected");
	a_en: assert property (p_en) else $error("store while disabled");
	a_word: assert property (p_word) else $error("stored word wrong");
	a_pulse: assert property (p_pulse) else $error("store pulse too long");
	a_trst: assert property (p_trst) else $error("test reset ignored");
	a_cold: assert property (p_cold) else $error("ready without reset");
	a_gate: assert property (p_gate) else $error("drive before reset");
	a_drop: assert property (p_drop) else $error("drive not dropped");
	a_fall: assert property (p_fall) else $error("drive not on fall");
	c_store: cover property (wr_store);
	c_ready: cover property ($rose(tap_ready));
	c_drive: cover property ($rose(data_out_en));
endmodule
bind fwptr_top fwptr_mon mon(.*);

// ### fwptr_writer_model.sv
// Writer and test-host model on the far side of fwptr_top.
`timescale 1ns/1ns
module fwptr_writer_model
	import fwptr_pkg::*;
(
	input  logic        mclk,                  // Clock.
	output logic        write_clk = 1'h0,      // Strobe.
	output logic        write_en_n = 1'h1,     // Enable.
	output logic        write_select_n = 1'h1, // Select.
	output fwptr_word_t write_data = 36'h0,    // Data.
	output logic        tck = 1'h0,            // Test clock.
	output logic        tms = 1'h1,            // Mode select.
	output logic        tms_driven = 1'h1,     // Pin driven.
	output logic        trst_n = 1'h1          // Test reset.
);
	task automatic wr(input logic sel_n, en_n, input fwptr_word_t d);
		@(negedge mclk);
		write_select_n = sel_n;
		write_en_n = en_n;
		write_data = d;
		repeat (4) @(negedge mclk);
		write_clk = 1'h1;
		repeat (4) @(negedge mclk);
		write_clk = 1'h0;
		write_data = ~d;
	endtask
	task automatic tk(input int n, input logic m, drv);
		repeat (n) begin
			@(negedge mclk);
			tms_driven = drv;
			// A floating pin is shown low so that only the pull-up reading can pass.
			tms = drv ? m : 1'h0;
			repeat (6) @(negedge mclk);
			tck = 1'h1;
			repeat (6) @(negedge mclk);
			tck = 1'h0;
		end
	endtask
	task automatic pulse_trst();
		@(negedge mclk);
		trst_n = 1'h0;
		repeat (6) @(negedge mclk);
		trst_n = 1'h1;
	endtask
endmodule

// ### test_fifo_write_port_and_tap_reset.sv
// Self-checking bench for the write-port qualifier and test-reset gate.
`timescale 1ns/1ns
module test_fifo_write_port_and_tap_reset;
	import fwptr_pkg::*;
	logic mclk = 1'h0, rst_n = 1'h0, mrst_n = 1'h0, async_mode = 1'h0, strap = 1'h1, data_oe = 1'h1;
	logic wclk, wen_n, wsel_n, tck, tms, tms_driven, trst_n, wr_store, io_q, tap_ready, data_out_en;
	fwptr_word_t wdata, wr_word, d;
	fwptr_word_t q[$];
	int errors = 0, checks_done = 0, seed = 32'hA888E0C4;
	always #20 mclk = ~mclk;
	fwptr_writer_model w(.mclk(mclk), .write_clk(wclk), .write_en_n(wen_n), .write_select_n(wsel_n),
		.write_data(wdata), .tck(tck), .tms(tms), .tms_driven(tms_driven), .trst_n(trst_n));
	fwptr_top dut(.mclk(mclk), .rst_n(rst_n), .master_reset_n(mrst_n), .write_timing_async(async_mode),
		.write_port_io_standard_select(strap), .write_clk(wclk), .write_en_n(wen_n), .write_select_n(wsel_n),
		.write_data(wdata), .tck(tck), .tms(tms), .tms_driven(tms_driven), .trst_n(trst_n), .data_oe(data_oe),
		.wr_store(wr_store), .wr_word(wr_word), .io_standard_q(io_q), .tap_ready(tap_ready),
		.data_out_en(data_out_en));
	task chk(input string n, input logic [35:0] s, e);
		checks_done++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task finish_test();
		if (errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	always @(negedge mclk) if (wr_store === 1'h1) begin
		if (q.size() == 0) chk("stray", 1, 0);
		else chk("wr_word", wr_word, q.pop_front());
	end
	initial begin
		#1000000;
		errors++;
		finish_test();
	end
	initial begin
		repeat (8) @(negedge mclk);
		rst_n = 1'h1;
		@(negedge mclk);
		chk("tap_ready", tap_ready, 0);
		w.tk(2, 1'h1, 1'h1);
		mrst_n = 1'h1;
		strap = 1'h0;
		w.tk(1, 1'h0, 1'h1);
		chk("tap_ready", tap_ready, 0);
		w.tk(5, 1'h1, 1'h0);
		repeat (6) @(negedge mclk);
		chk("tap_ready", tap_ready, 1);
		chk("data_out_en", data_out_en, 1);
		chk("io_q", io_q, 1);
		data_oe = 1'h0;
		repeat (2) @(negedge mclk);
		chk("data_out_en", data_out_en, 0);
		data_oe = 1'h1;
		rst_n = 1'h0;
		repeat (8) @(negedge mclk);
		rst_n = 1'h1;
		@(negedge mclk);
		chk("tap_ready", tap_ready, 0);
		w.pulse_trst();
		chk("tap_ready", tap_ready, 1);
		for (int i = 0; i < 8; i++) begin
			d = fwptr_word_t'({$random(seed), $random(seed)});
			repeat (4) @(negedge mclk);
			async_mode = i[2];
			if (!i[0] && (i[2] || !i[1])) q.push_back(d);
			w.wr(i[0], i[1] & !i[2], d);
		end
		repeat (10) @(negedge mclk);
		chk("pending", 36'(q.size()), 0);
		finish_test();
	end
endmodule
